/* File: src/dpc_consts.svh */
// Timing constants and field positions for the two-port memory controller
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH
`define DPC_CLK_PERIOD_NS     20
`define DPC_ACCESS_NS         20
`define DPC_WRITE_PULSE_NS    15
`define DPC_HZWE_NS           12
`define DPC_DATA_SETUP_NS     15
`define DPC_FLAG_PULSE_NS     10
`define DPC_SLAVE_EXTEND_NS   15
`define DPC_RELEASE_DATA_NS   20
`define DPC_RECOVERY_NS       20
`define DPC_CEIL(ns) (((ns) + `DPC_CLK_PERIOD_NS - 1) / `DPC_CLK_PERIOD_NS)
`define DPC_FLAG_BIT          0
`define DPC_FLAG_FREE         1'b1
`define DPC_FLAG_TAKE         1'b0
`endif

/* File: src/dpc_pkg.sv */
// Types for the two-port memory controller
package dpc_pkg;
  typedef enum logic [1:0] {
    DPC_OP_READ,
    DPC_OP_WRITE,
    DPC_OP_FLAG_READ,
    DPC_OP_FLAG_WRITE
  } dpc_op_t;
  typedef enum {
    DPC_IDLE,
    DPC_SETUP,
    DPC_STROBE,
    DPC_BUSY_WAIT,
    DPC_EXTEND,
    DPC_RECOVER
  } dpc_state_t;
endpackage

/* File: src/dpc_sync.sv */
// Three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ns
module dpc_sync
  import dpc_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  // Per-bit chain; stage1 feeds only stage2
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
          stage1[gi] <= INIT[gi];
          stage2[gi] <= INIT[gi];
          stage3[gi] <= INIT[gi];
          sync_o[gi] <= INIT[gi];
        end else begin
          stage1[gi] <= async_i[gi];
          stage2[gi] <= stage1[gi];
          stage3[gi] <= stage2[gi];
          if (stage2[gi] == stage3[gi]) begin
            sync_o[gi] <= stage3[gi];
          end
        end
      end
    end
  endgenerate
endmodule // dpc_sync

/* File: src/dpc_ctrl.sv */
// Host-side controller for one port of an asynchronous two-port memory
`timescale 1ns/1ns
`include "dpc_consts.svh"
// Summary of operation
// - Direction held at read through reads
// - Direction at read whenever address changes
// - Stretch write pulse when output drive on
// - Slave write held past busy high
// - Flag update pulse of minimum width
// - Select inactive until supply recovered, once any access already under way has ended
module dpc_ctrl
  import dpc_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int DATA_W = 16
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              req_i,
  input  wire dpc_op_t           req_op_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  input  wire logic [1:0]        req_lanes_i,
  input  wire logic              supply_ok_i,
  output logic                   req_ready_o,
  output logic                   done_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic                   mailbox_irq_o,
  output logic [ADDR_W-1:0]      addr_o,
  output logic                   select_n_o,
  output logic                   flag_select_n_o,
  output logic                   write_n_o,
  output logic                   out_drive_n_o,
  output logic                   upper_lane_n_o,
  output logic                   lower_lane_n_o,
  output logic [DATA_W-1:0]      data_o,
  output logic                   data_oe_n_o,
  input  wire logic [DATA_W-1:0] data_i,
  input  wire logic              busy_n_i,
  input  wire logic              irq_n_i
);
  localparam int ACC_CYC  = `DPC_CEIL(`DPC_ACCESS_NS);
  localparam int WR_NS_A  = `DPC_HZWE_NS + `DPC_DATA_SETUP_NS;
  // Longest of plain pulse and turn-off plus setup
  localparam int WR_NS    = (WR_NS_A > `DPC_WRITE_PULSE_NS) ?
                            WR_NS_A : `DPC_WRITE_PULSE_NS;
  localparam int WR_CYC   = `DPC_CEIL(WR_NS);
  localparam int FLG_CYC  = `DPC_CEIL(`DPC_FLAG_PULSE_NS);
  localparam int EXT_CYC  = `DPC_CEIL(`DPC_SLAVE_EXTEND_NS);
  localparam int BDD_CYC  = `DPC_CEIL(`DPC_RELEASE_DATA_NS);
  localparam int REC_CYC  = `DPC_CEIL(`DPC_RECOVERY_NS);
  localparam int CNT_W    = 4;

  // Odd or tiny data widths cannot be split into two byte lanes
  if (ADDR_W < 1 || DATA_W < 2 || (DATA_W % 2) != 0) begin : g_bad_width
    $error("dpc_ctrl: unsupported width");
  end

  dpc_state_t        state;
  logic [CNT_W-1:0]  cnt;
  dpc_op_t           op;
  logic              powered;
  logic              busy_n_s;
  logic              irq_n_s;
  logic              is_write;
  logic              is_flag;
  logic [CNT_W-1:0]  strobe_len;
  logic [1:0]        req_lanes_q;

  // Busy and interrupt pin inputs pass the three-stage synchroniser
  dpc_sync #(.WIDTH(2), .INIT(2'b11)) u_sync (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .async_i    ({busy_n_i, irq_n_i}),
    .sync_o     ({busy_n_s, irq_n_s})
  );

  assign is_write = (op == DPC_OP_WRITE) || (op == DPC_OP_FLAG_WRITE);
  assign is_flag  = (op == DPC_OP_FLAG_READ) || (op == DPC_OP_FLAG_WRITE);
  // Flag strobe uses its own minimum; RAM write the stretched pulse
  assign strobe_len = is_flag ? CNT_W'(FLG_CYC) :
                      is_write ? CNT_W'(WR_CYC) : CNT_W'(ACC_CYC);

  // Power gate: no access until the recovery count runs out after supply is good
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      powered <= 1'b0;
    end else if (!supply_ok_i) begin
      powered <= 1'b0;
    end else if (state == DPC_RECOVER && cnt == '0) begin
      powered <= 1'b1;
    end
  end

  // Access sequencer; setup phase puts address with direction at read
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      state <= DPC_RECOVER;
      cnt   <= CNT_W'(REC_CYC);
      op    <= DPC_OP_READ;
    end else begin
      case (state)
        DPC_RECOVER: begin
          if (!supply_ok_i) begin
            cnt <= CNT_W'(REC_CYC);
          end else if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= DPC_IDLE;
          end
        end
        DPC_IDLE: begin
          if (!supply_ok_i) begin
            state <= DPC_RECOVER;
            cnt   <= CNT_W'(REC_CYC);
          end else if (req_i && powered) begin
            op    <= req_op_i;
            state <= DPC_SETUP;
          end
        end
        DPC_SETUP: begin
          state <= DPC_STROBE;
          // Full count: write falls one cycle into the strobe, so the
          // pulse itself still lasts the whole length
          cnt   <= strobe_len;
        end
        DPC_STROBE: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else if (!busy_n_s && !is_flag) begin
            state <= DPC_BUSY_WAIT;
          end else begin
            state <= DPC_IDLE;
          end
        end
        DPC_BUSY_WAIT: begin
          if (busy_n_s) begin
            state <= DPC_EXTEND;
            // Extension for held write, data delay for held read
            cnt <= is_write ? CNT_W'(EXT_CYC) : CNT_W'(BDD_CYC);
          end
        end
        DPC_EXTEND: begin
          if (cnt != '0) begin
            cnt <= cnt - 1'b1;
          end else begin
            state <= DPC_IDLE;
          end
        end
        default: begin
          state <= DPC_IDLE;
        end
      endcase
    end
  end

  // Address and write data latched at request; stable through the access
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      addr_o <= '0;
      data_o <= '0;
    end else if (state == DPC_IDLE && req_i && powered) begin
      addr_o <= req_addr_i;
      data_o <= req_wdata_i;
    end
  end

  // Pin strobes; direction goes to write only after select is down
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      select_n_o      <= 1'b1;
      flag_select_n_o <= 1'b1;
      write_n_o       <= 1'b1;
      out_drive_n_o   <= 1'b1;
      upper_lane_n_o  <= 1'b1;
      lower_lane_n_o  <= 1'b1;
      data_oe_n_o     <= 1'b1;
    end else begin
      select_n_o      <= 1'b1;
      flag_select_n_o <= 1'b1;
      write_n_o       <= 1'b1;
      out_drive_n_o   <= 1'b1;
      upper_lane_n_o  <= 1'b1;
      lower_lane_n_o  <= 1'b1;
      data_oe_n_o     <= 1'b1;
      if (state == DPC_SETUP || state == DPC_STROBE ||
          state == DPC_BUSY_WAIT || state == DPC_EXTEND) begin
        // Flag access keeps both lanes high; select and flag never both
        select_n_o      <= is_flag;
        flag_select_n_o <= !is_flag;
        upper_lane_n_o  <= is_flag | !req_lanes_q[1];
        lower_lane_n_o  <= is_flag | !req_lanes_q[0];
        out_drive_n_o   <= is_write;
        // Write starts the cycle after select, ends with the strobe
        write_n_o   <= !(is_write && state != DPC_SETUP);
        data_oe_n_o <= !(is_write && state != DPC_SETUP);
        if (state == DPC_STROBE && cnt == '0 &&
            !(!busy_n_s && !is_flag)) begin
          select_n_o      <= 1'b1;
          flag_select_n_o <= 1'b1;
          write_n_o       <= 1'b1;
          upper_lane_n_o  <= 1'b1;
          lower_lane_n_o  <= 1'b1;
          out_drive_n_o   <= 1'b1;
        end
        if (state == DPC_EXTEND && cnt == '0) begin
          select_n_o     <= 1'b1;
          write_n_o      <= 1'b1;
          upper_lane_n_o <= 1'b1;
          lower_lane_n_o <= 1'b1;
          out_drive_n_o  <= 1'b1;
        end
      end
    end
  end

  // Lane choice held for the access
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req_lanes_q <= 2'b00;
    end else if (state == DPC_IDLE && req_i && powered) begin
      req_lanes_q <= req_lanes_i;
    end
  end

  // Read data captured at the last strobe cycle, or at the end of the extension after busy; one-cycle done pulse
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_o <= '0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if ((state == DPC_STROBE && cnt == '0 && (busy_n_s || is_flag)) ||
          (state == DPC_EXTEND && cnt == '0)) begin
        done_o <= 1'b1;
        if (!is_write) begin
          rdata_o <= data_i;
        end
      end
    end
  end

  // Ready and mailbox interrupt level from the synchronised pin
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      req_ready_o   <= 1'b0;
      mailbox_irq_o <= 1'b0;
    end else begin
      req_ready_o   <= (state == DPC_IDLE) && powered && !req_i;
      mailbox_irq_o <= !irq_n_s;
    end
  end

  chk_write_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !write_n_o |-> ((!select_n_o || !flag_select_n_o) &&
                    (!upper_lane_n_o || !lower_lane_n_o || !flag_select_n_o)))
    else $error("write without select");
  chk_read_dir: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $changed(addr_o) |-> write_n_o)
    else $error("address changed while writing");
  chk_select_first: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(write_n_o) |-> $past(!select_n_o || !flag_select_n_o))
    else $error("write before select");
  chk_write_len: assert property (@(posedge core_clk_i) disable iff (reset_i)
    ($fell(write_n_o) && !select_n_o) |-> !write_n_o [*2])
    else $error("write pulse too short");
  chk_flag_lanes: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !flag_select_n_o |-> (upper_lane_n_o && lower_lane_n_o && select_n_o))
    else $error("flag access with lanes");
  chk_power_gate: assert property (@(posedge core_clk_i) disable iff (reset_i)
    !powered |-> (select_n_o && flag_select_n_o))
    else $error("select before supply");
  chk_flag_pulse: assert property (@(posedge core_clk_i) disable iff (reset_i)
    $fell(flag_select_n_o) |-> !flag_select_n_o [*2])
    else $error("flag pulse short");
  chk_busy_hold: assert property (@(posedge core_clk_i) disable iff (reset_i)
    (state == DPC_BUSY_WAIT && is_write) |-> !write_n_o)
    else $error("write dropped under busy");
  cov_write: cover property (@(posedge core_clk_i) $fell(write_n_o));
  cov_flag: cover property (@(posedge core_clk_i) $fell(flag_select_n_o));
  cov_busy: cover property (@(posedge core_clk_i) state == DPC_BUSY_WAIT);
endmodule // dpc_ctrl

/* File: sim/dpc_dev_model.sv */
// Behavioural model of one port of the two-port memory, slave role
`timescale 1ns/1ns
module dpc_dev_model (
  input  wire logic        core_clk_i,
  input  wire logic [13:0] addr_i,
  input  wire logic        select_n_i,
  input  wire logic        flag_select_n_i,
  input  wire logic        write_n_i,
  input  wire logic        out_drive_n_i,
  input  wire logic        upper_lane_n_i,
  input  wire logic        lower_lane_n_i,
  input  wire logic [15:0] bus_i,
  input  wire logic        busy_hold_i,
  input  wire logic        mail_set_i,
  output logic      [15:0] bus_o,
  output logic             busy_n_o,
  output logic             irq_n_o
);
  logic [15:0] mem [0:15];
  logic [15:0] last_bus;
  logic        flag;
  logic        mail;
  logic        ram_sel;
  logic        sem_sel;
  logic        rd_en;

  // Free flag, quiet mailbox and a known bus history at start of operation
  initial begin
    flag = 1'b1;
    mail = 1'b0;
    last_bus = 16'h0000;
  end

  // Only a low select with a high flag select reaches the array
  assign ram_sel  = !select_n_i && flag_select_n_i;
  assign sem_sel  = select_n_i && !flag_select_n_i;
  assign rd_en    = write_n_i && !out_drive_n_i;
  // Hold-off stands for the other port winning a matching address
  assign busy_n_o = !busy_hold_i;
  assign irq_n_o  = !mail;

  // Sampled on the falling edge, well inside each controller strobe
  always @(negedge core_clk_i) begin
    last_bus <= bus_i;
    if (!write_n_i && busy_n_o) begin
      if (ram_sel && !upper_lane_n_i) begin
        mem[addr_i[3:0]][15:8] <= bus_i[15:8];
      end
      if (ram_sel && !lower_lane_n_i) begin
        mem[addr_i[3:0]][7:0] <= bus_i[7:0];
      end
      if (sem_sel) begin
        flag <= bus_i[0];
      end
    end
    if (mail_set_i) begin
      mail <= 1'b1;
    end else if (ram_sel && rd_en && addr_i == 14'h3fff) begin
      mail <= 1'b0;
    end
  end

  // Undriven lanes show the inverse of the last bus value, never a copy
  always_comb begin
    bus_o = ~last_bus;
    if (ram_sel && rd_en && !upper_lane_n_i) begin
      bus_o[15:8] = mem[addr_i[3:0]][15:8];
    end
    if (ram_sel && rd_en && !lower_lane_n_i) begin
      bus_o[7:0] = mem[addr_i[3:0]][7:0];
    end
    if (sem_sel && rd_en) begin
      bus_o = {15'h0000, flag};
    end
  end
endmodule // dpc_dev_model

/* File: sim/dual_port_ram_arbitration_test.sv */
// Self-checking bench for the two-port memory controller
`timescale 1ns/1ns
module dual_port_ram_arbitration_test;
  import dpc_pkg::*;
  logic        core_clk_i, reset_i, req_i, supply_ok_i, busy_hold, mail_set;
  dpc_op_t     req_op_i;
  logic [13:0] req_addr_i, addr_o;
  logic [15:0] req_wdata_i, rdata_o, data_o, dev_bus, pin_bus;
  logic [1:0]  req_lanes_i;
  logic        req_ready_o, done_o, mailbox_irq_o, select_n_o, flag_select_n_o;
  logic        write_n_o, out_drive_n_o, upper_lane_n_o, lower_lane_n_o;
  logic        data_oe_n_o, busy_n, irq_n;
  int          mismatches, checked;

  // Wire level: the controller wins only while its enable is low
  assign pin_bus = data_oe_n_o ? dev_bus : data_o;

  dpc_ctrl dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .req_i(req_i),
    .req_op_i(req_op_i), .req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i),
    .req_lanes_i(req_lanes_i), .supply_ok_i(supply_ok_i),
    .req_ready_o(req_ready_o), .done_o(done_o), .rdata_o(rdata_o),
    .mailbox_irq_o(mailbox_irq_o), .addr_o(addr_o), .select_n_o(select_n_o),
    .flag_select_n_o(flag_select_n_o), .write_n_o(write_n_o),
    .out_drive_n_o(out_drive_n_o), .upper_lane_n_o(upper_lane_n_o),
    .lower_lane_n_o(lower_lane_n_o), .data_o(data_o),
    .data_oe_n_o(data_oe_n_o), .data_i(pin_bus), .busy_n_i(busy_n),
    .irq_n_i(irq_n));

  dpc_dev_model u_dev (.core_clk_i(core_clk_i), .addr_i(addr_o),
    .select_n_i(select_n_o), .flag_select_n_i(flag_select_n_o),
    .write_n_i(write_n_o), .out_drive_n_i(out_drive_n_o),
    .upper_lane_n_i(upper_lane_n_o), .lower_lane_n_i(lower_lane_n_o),
    .bus_i(pin_bus), .busy_hold_i(busy_hold), .mail_set_i(mail_set),
    .bus_o(dev_bus), .busy_n_o(busy_n), .irq_n_o(irq_n));

  // 50 MHz clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string msg);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  // One request held until done; a missing completion counts as a mismatch
  task automatic run_op(input dpc_op_t op, input logic [13:0] a,
                        input logic [15:0] d, input logic [1:0] ln);
    int n;
    @(negedge core_clk_i);
    req_i = 1'b1;
    req_op_i = op;
    req_addr_i = a;
    req_wdata_i = d;
    req_lanes_i = ln;
    n = 0;
    do begin
      @(posedge core_clk_i);
      #1 n++;
    end while (done_o !== 1'b1 && n < 300);
    if (n >= 300) begin
      mismatches++;
      $display("unexpected at %0t: no completion", $time);
    end
    @(negedge core_clk_i);
    req_i = 1'b0;
  endtask

  task automatic t_word;
    run_op(DPC_OP_WRITE, 14'h0005, 16'ha5c3, 2'b11);
    @(posedge core_clk_i);
    #1 check({15'h0000, req_ready_o}, 16'h0001, "ready when idle");
    run_op(DPC_OP_READ, 14'h0005, 16'h0000, 2'b11);
    check(rdata_o, 16'ha5c3, "word read");
    check(u_dev.mem[5], 16'ha5c3, "read left array alone");
  endtask

  // Each lane written alone must leave the other byte untouched
  task automatic t_lanes;
    run_op(DPC_OP_WRITE, 14'h0005, 16'h1234, 2'b10);
    run_op(DPC_OP_READ, 14'h0005, 16'h0000, 2'b11);
    check(rdata_o, 16'h12c3, "upper lane write");
    run_op(DPC_OP_WRITE, 14'h0005, 16'hff77, 2'b01);
    run_op(DPC_OP_READ, 14'h0005, 16'h0000, 2'b01);
    check({8'h00, rdata_o[7:0]}, 16'h0077, "lower lane read");
    check(u_dev.mem[5], 16'h1277, "lower lane write");
  endtask

  task automatic t_flag;
    for (int v = 0; v < 2; v++) begin
      run_op(DPC_OP_FLAG_WRITE, 14'h0000, 16'(v), 2'b00);
      run_op(DPC_OP_FLAG_READ, 14'h0000, 16'h0000, 2'b00);
      check({15'h0000, rdata_o[0]}, 16'(v), "flag value");
    end
  endtask

  // Busy held during a write: nothing commits until it is released
  task automatic t_busy;
    @(negedge core_clk_i);
    busy_hold = 1'b1;
    fork
      run_op(DPC_OP_WRITE, 14'h0009, 16'h5aa5, 2'b11);
      begin
        repeat (12) @(posedge core_clk_i);
        #1 check(u_dev.mem[9], 16'h0000, "write held off");
        @(negedge core_clk_i);
        busy_hold = 1'b0;
      end
    join
    run_op(DPC_OP_READ, 14'h0009, 16'h0000, 2'b11);
    check(rdata_o, 16'h5aa5, "held write completes");
    // Read held off by busy: data only after the release
    @(negedge core_clk_i);
    busy_hold = 1'b1;
    fork
      run_op(DPC_OP_READ, 14'h0005, 16'h0000, 2'b11);
      begin
        repeat (12) @(posedge core_clk_i);
        #1 check({15'h0000, done_o}, 16'h0000, "read held off");
        @(negedge core_clk_i);
        busy_hold = 1'b0;
      end
    join
    check(rdata_o, 16'h1277, "held read data");
  endtask

  task automatic t_mail;
    @(negedge core_clk_i);
    mail_set = 1'b1;
    // Two falling edges so the model surely sees it
    repeat (2) @(negedge core_clk_i);
    mail_set = 1'b0;
    repeat (5) @(posedge core_clk_i);
    #1 check({15'h0000, mailbox_irq_o}, 16'h0001, "mailbox set");
    run_op(DPC_OP_READ, 14'h3fff, 16'h0000, 2'b11);
    repeat (5) @(posedge core_clk_i);
    #1 check({15'h0000, mailbox_irq_o}, 16'h0000, "mailbox clear");
  endtask

  // Supply loss: select stays inactive until recovery
  task automatic t_supply;
    @(negedge core_clk_i);
    supply_ok_i = 1'b0;
    fork
      run_op(DPC_OP_READ, 14'h0009, 16'h0000, 2'b11);
      begin
        repeat (20) @(posedge core_clk_i);
        #1 check({15'h0000, select_n_o}, 16'h0001, "select in loss");
        check({15'h0000, req_ready_o}, 16'h0000, "no ready in loss");
        @(negedge core_clk_i);
        supply_ok_i = 1'b1;
      end
    join
    check(rdata_o, 16'h5aa5, "read after recovery");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard, far beyond the fewer than two hundred cycles the tests need
  initial begin
    #400000;
    mismatches++;
    test_done;
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checked = 0;
    reset_i = 1'b1;
    req_i = 1'b0;
    req_op_i = DPC_OP_READ;
    req_addr_i = 14'h0000;
    req_wdata_i = 16'h0000;
    req_lanes_i = 2'b00;
    supply_ok_i = 1'b1;
    busy_hold = 1'b0;
    mail_set = 1'b0;
    u_dev.mem[9] = 16'h0000;
    repeat (6) @(negedge core_clk_i);
    reset_i = 1'b0;
    #1 check({12'h000, select_n_o, flag_select_n_o, write_n_o, data_oe_n_o},
             16'h000f, "idle strobes");
    t_word;
    t_lanes;
    t_flag;
    t_busy;
    t_mail;
    t_supply;
    test_done;
  end
endmodule // dual_port_ram_arbitration_test
